// *** mgmt_pkg.sv ***
package mgmt_pkg;
  // ---------------------------------------------------------------
  // Port geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int WM_W = 11;
  localparam int LEN_W = 16;
  // ---------------------------------------------------------------
  // Device register map
  // ---------------------------------------------------------------
  localparam logic [9:0] OFS_IST = 10'h040;
  localparam logic [9:0] OFS_IMASK = 10'h044;
  localparam logic [9:0] OFS_OVF = 10'h048;
  localparam logic [9:0] OFS_STATCMD = 10'h050;
  localparam logic [9:0] OFS_TXWM = 10'h060;
  localparam logic [9:0] OFS_STA = 10'h070;
  localparam logic [9:0] OFS_LSA = 10'h080;
  localparam logic [1:0] STATS_PAGE = 2'h1;
  localparam int WM_LOW_LSB = 0;
  localparam int WM_HIGH_LSB = 16;
  localparam logic [10:0] WM_LOW_RST = 11'h100;
  localparam logic [10:0] WM_HIGH_RST = 11'h300;
  localparam int STATCMD_TRACK = 0;
  localparam int STATCMD_SNAP = 1;
  // Interrupt status bits
  localparam int IST_W = 4;
  localparam int IST_OVF = 0;
  localparam int IST_RXERR = 1;
  localparam int IST_TXERR = 2;
  localparam int IST_SNAP = 3;
  localparam logic [3:0] IMASK_RST = 4'hf;
  // ---------------------------------------------------------------
  // Statistics counter indices (32-bit), octet words follow
  // ---------------------------------------------------------------
  localparam int N_BIN = 6;
  localparam int N_ERR = 10;
  localparam int N_RX_ERR = 6;
  localparam int CNT_RX_BIN = 0;
  localparam int CNT_RX_OK = 6;
  localparam int CNT_TX_BIN = 7;
  localparam int CNT_TX_OK = 13;
  localparam int CNT_ERR = 14;
  localparam int CNT_RX_UTIL = 24;
  localparam int CNT_TX_UTIL = 25;
  localparam int N_CNT = 26;
  localparam int N_OCT = 2;
  // Frame length bins
  localparam logic [15:0] LEN_MIN = 16'h0040;
  localparam logic [15:0] LEN_B1 = 16'h007f;
  localparam logic [15:0] LEN_B2 = 16'h00ff;
  localparam logic [15:0] LEN_B3 = 16'h01ff;
  localparam logic [15:0] LEN_B4 = 16'h03ff;
  localparam logic [15:0] LEN_MAX = 16'h05ee;
  localparam logic [15:0] LEN_TAG = 16'h0004;
  // ---------------------------------------------------------------
  // Controller (host end) register map on Wishbone
  // ---------------------------------------------------------------
  localparam logic [7:0] HC_CTRL = 8'h00;
  localparam logic [7:0] HC_ADDR = 8'h04;
  localparam logic [7:0] HC_WDATA = 8'h08;
  localparam logic [7:0] HC_STATUS = 8'h0c;
  localparam logic [7:0] HC_RDATA = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_WIDE = 2;
  localparam int CTRL_LEN_LSB = 8;

  typedef enum logic [0:0] {D_IDLE, D_BURST} dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_FIRST, H_STREAM, H_GAP} host_state_t;

  // Length bin 0..5, or 7 when the frame falls in no bin
  function automatic logic [2:0] len_bin(input logic [15:0] len, input logic tagged_f);
    logic [15:0] top;
    top = tagged_f ? LEN_MAX + LEN_TAG : LEN_MAX;
    if (len < LEN_MIN || len > top) len_bin = 3'h7;
    else if (len == LEN_MIN) len_bin = 3'h0;
    else if (len <= LEN_B1) len_bin = 3'h1;
    else if (len <= LEN_B2) len_bin = 3'h2;
    else if (len <= LEN_B3) len_bin = 3'h3;
    else if (len <= LEN_B4) len_bin = 3'h4;
    else len_bin = 3'h5;
  endfunction : len_bin
endpackage : mgmt_pkg

// *** mgmt_port_if.sv ***
`timescale 1ns/1ps
interface mgmt_port_if;
  logic mgmt_port_select_n;
  logic [9:0] addr;
  logic we;
  logic [31:0] wdata;
  logic wide;
  logic [31:0] rdata;
  logic mgmt_port_ready;
  logic irq;
  modport dev (
    input mgmt_port_select_n, addr, we, wdata, wide,
    output rdata, mgmt_port_ready, irq
  );
  modport host (
    output mgmt_port_select_n, addr, we, wdata, wide,
    input rdata, mgmt_port_ready, irq
  );
endinterface : mgmt_port_if

// *** stat_bank.sv ***
`timescale 1ns/1ps
module stat_bank #(
  parameter int N = mgmt_pkg::N_CNT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [N-1:0] i_inc,
  input wire logic [15:0] i_rx_oct,
  input wire logic [15:0] i_tx_oct,
  input wire logic i_track,
  input wire logic i_snap,
  input wire logic [5:0] i_idx,
  output logic [31:0] o_data,
  output logic [N+1:0] o_wrap
);
  import mgmt_pkg::*;

  typedef struct packed {
    logic [N-1:0][31:0] live;
    logic [N-1:0][31:0] snap;
    logic [1:0][63:0] oct_live;
    logic [1:0][63:0] oct_snap;
  } bank_t;
  bank_t s_r, s_nxt;
  logic [1:0][15:0] oct_add;
  logic [64:0] osum;

  assign oct_add = {i_tx_oct, i_rx_oct};

  // ---------------------------------------------------------------
  // Live counters and atomic copy
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    o_wrap = '0;
    osum = '0;
    for (int i = 0; i < N; i++) begin
      if (i_inc[i]) begin
        s_nxt.live[i] = s_r.live[i] + 32'h1;
        o_wrap[i] = &s_r.live[i];
      end
    end
    for (int k = 0; k < 2; k++) begin
      osum = {1'b0, s_r.oct_live[k]} + {49'h0, oct_add[k]};
      s_nxt.oct_live[k] = osum[63:0];
      o_wrap[N+k] = osum[64];
    end
    // Whole set copied in one edge: tracking or on a snap strobe
    if (i_track || i_snap) begin
      s_nxt.snap = s_r.live;
      s_nxt.oct_snap = s_r.oct_live;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    o_data = 32'h0;
    if (int'(i_idx) < N) o_data = s_r.snap[i_idx];
    else if (int'(i_idx) < N + 2 * N_OCT) begin
      o_data = i_idx[0] ? s_r.oct_snap[(int'(i_idx) - N) / 2][63:32]
                        : s_r.oct_snap[(int'(i_idx) - N) / 2][31:0];
    end
  end
endmodule : stat_bank

// *** mgmt_port_dev.sv ***
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module mgmt_port_dev (
  input wire logic i_clk,
  input wire logic i_rst_n,
  mgmt_port_if.dev port,
  input wire logic i_rx_done,
  input wire logic i_rx_good,
  input wire logic i_rx_tagged,
  input wire logic [mgmt_pkg::LEN_W-1:0] i_rx_len,
  input wire logic i_tx_done,
  input wire logic i_tx_good,
  input wire logic i_tx_tagged,
  input wire logic [mgmt_pkg::LEN_W-1:0] i_tx_len,
  input wire logic [mgmt_pkg::N_ERR-1:0] i_err_evt,
  input wire logic i_rx_busy,
  input wire logic i_tx_busy,
  input wire logic [mgmt_pkg::WM_W-1:0] i_tx_fifo_words,
  input wire logic [47:0] i_last_src,
  output logic [47:0] o_station_addr,
  output logic [mgmt_pkg::WM_W-1:0] o_tx_low_wm,
  output logic [mgmt_pkg::WM_W-1:0] o_tx_high_wm,
  output logic o_tx_almost_empty,
  output logic o_tx_almost_full
);
  import mgmt_pkg::*;

  typedef struct packed {
    dev_state_t state;
    logic [9:0] s1_addr;
    logic s1_we;
    logic [31:0] s1_wd;
    logic s1_fresh;
    logic s1_wide;
    logic [31:0] rdata;
    logic ready;
    logic irq;
    logic [WM_W-1:0] wm_low;
    logic [WM_W-1:0] wm_high;
    logic [2:0][15:0] sta;
    logic [IST_W-1:0] ist;
    logic [IST_W-1:0] imask;
    logic [N_CNT+1:0] ovf;
    logic track;
    logic snap;
    logic [47:0] sta_out;
    logic ae;
    logic af;
  } dev_t;
  dev_t s_r, s_nxt;

  logic [N_CNT-1:0] inc;
  logic [31:0] bank_data;
  logic [N_CNT+1:0] wrap;
  logic [2:0] rx_b, tx_b;
  logic rx_ok, tx_ok;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // First word carries bits 47:32 with 47:40 in its low byte
  function automatic logic [15:0] addr_word(input logic [47:0] a, input int w);
    logic [15:0] hw;
    hw = a[47 - 16 * w -: 16];
    addr_word = {hw[7:0], hw[15:8]};
  endfunction : addr_word

  function automatic logic [31:0] half_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic wide, input logic upper);
    if (wide) half_merge = wd;
    else if (upper) half_merge = {wd[15:0], old[15:0]};
    else half_merge = {old[31:16], wd[15:0]};
  endfunction : half_merge

  // ---------------------------------------------------------------
  // Statistics events
  // ---------------------------------------------------------------
  assign rx_ok = i_rx_done && i_rx_good;
  assign tx_ok = i_tx_done && i_tx_good;
  assign rx_b = len_bin(i_rx_len, i_rx_tagged);
  assign tx_b = len_bin(i_tx_len, i_tx_tagged);

  always_comb begin
    inc = '0;
    for (int i = 0; i < N_BIN; i++) begin
      inc[CNT_RX_BIN + i] = rx_ok && int'(rx_b) == i;
      inc[CNT_TX_BIN + i] = tx_ok && int'(tx_b) == i;
    end
    inc[CNT_RX_OK] = rx_ok;
    inc[CNT_TX_OK] = tx_ok;
    inc[CNT_ERR +: N_ERR] = i_err_evt;
    inc[CNT_RX_UTIL] = i_rx_busy;
    inc[CNT_TX_UTIL] = i_tx_busy;
  end

  stat_bank #(.N(N_CNT)) u_bank (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_inc(inc),
    .i_rx_oct(rx_ok ? i_rx_len : 16'h0),
    .i_tx_oct(tx_ok ? i_tx_len : 16'h0),
    .i_track(s_r.track),
    .i_snap(s_r.snap),
    .i_idx(s_r.s1_addr[7:2]),
    .o_data(bank_data),
    .o_wrap(wrap)
  );

  // ---------------------------------------------------------------
  // Access pipeline and registers
  // ---------------------------------------------------------------
  always_comb begin
    logic sel;
    logic fresh;
    logic aligned;
    logic rd;
    logic wr;
    logic [9:0] wa;
    logic [31:0] v;
    logic [31:0] nw;
    logic [IST_W-1:0] ist_clr;
    logic [N_CNT+1:0] ovf_clr;
    sel = !port.mgmt_port_select_n;
    s_nxt = s_r;
    ist_clr = '0;
    ovf_clr = '0;
    v = 32'h0;
    nw = 32'h0;
    fresh = 1'b0;
    aligned = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    wa = 10'h0;
    // Stay in burst until select is released
    s_nxt.state = sel ? D_BURST : D_IDLE;
    // A fresh access is a new address seen while selected
    fresh = sel && (s_r.state == D_IDLE || port.addr != s_r.s1_addr);
    s_nxt.s1_addr = port.addr;
    s_nxt.s1_we = port.we;
    s_nxt.s1_wd = port.wdata;
    s_nxt.s1_wide = port.wide;
    s_nxt.s1_fresh = fresh;
    // Second stage: data lands in the third clock of the address
    aligned = s_r.s1_wide ? s_r.s1_addr[1:0] == 2'b00 : !s_r.s1_addr[0];
    // No read data once select is gone, so data never stands without ready
    rd = s_r.s1_fresh && aligned && !s_r.s1_we && sel;
    wr = s_r.s1_fresh && aligned && s_r.s1_we;
    wa = {s_r.s1_addr[9:2], 2'b00};
    if (s_r.s1_addr[9:8] == STATS_PAGE) v = bank_data;
    else begin
      case (wa)
        OFS_IST: v = {{(32 - IST_W){1'b0}}, s_r.ist};
        OFS_IMASK: v = {{(32 - IST_W){1'b0}}, s_r.imask};
        OFS_OVF: v = {{(32 - N_CNT - 2){1'b0}}, s_r.ovf};
        OFS_STATCMD: v = {31'h0, s_r.track};
        OFS_TXWM: v = {5'h0, s_r.wm_high, 5'h0, s_r.wm_low};
        OFS_STA: v = {16'h0, s_r.sta[0]};
        OFS_STA + 10'h4: v = {16'h0, s_r.sta[1]};
        OFS_STA + 10'h8: v = {16'h0, s_r.sta[2]};
        OFS_LSA: v = {16'h0, addr_word(i_last_src, 0)};
        OFS_LSA + 10'h4: v = {16'h0, addr_word(i_last_src, 1)};
        OFS_LSA + 10'h8: v = {16'h0, addr_word(i_last_src, 2)};
        default: v = 32'h0;
      endcase
    end
    s_nxt.ready = s_r.s1_fresh && sel;
    s_nxt.rdata = 32'h0;
    if (rd) begin
      s_nxt.rdata = s_r.s1_wide ? v : {16'h0, s_r.s1_addr[1] ? v[31:16] : v[15:0]};
      if (wa == OFS_IST) ist_clr = '1;
      if (wa == OFS_OVF) ovf_clr = '1;
    end
    s_nxt.snap = 1'b0;
    if (wr) begin
      nw = half_merge(v, s_r.s1_wd, s_r.s1_wide, s_r.s1_addr[1]);
      case (wa)
        OFS_IMASK: s_nxt.imask = nw[IST_W-1:0];
        OFS_STATCMD: begin
          s_nxt.track = nw[STATCMD_TRACK];
          s_nxt.snap = nw[STATCMD_SNAP];
        end
        OFS_TXWM: begin
          s_nxt.wm_low = nw[WM_LOW_LSB +: WM_W];
          s_nxt.wm_high = nw[WM_HIGH_LSB +: WM_W];
        end
        OFS_STA: s_nxt.sta[0] = nw[15:0];
        OFS_STA + 10'h4: s_nxt.sta[1] = nw[15:0];
        OFS_STA + 10'h8: s_nxt.sta[2] = nw[15:0];
        default: ;
      endcase
    end
    // Interrupt status: a new event wins over a clearing read
    s_nxt.ovf = (s_r.ovf & ~ovf_clr) | wrap;
    s_nxt.ist = s_r.ist & ~ist_clr;
    s_nxt.ist[IST_OVF] = s_nxt.ist[IST_OVF] | (|wrap);
    s_nxt.ist[IST_RXERR] = s_nxt.ist[IST_RXERR] | (|i_err_evt[N_RX_ERR-1:0]);
    s_nxt.ist[IST_TXERR] = s_nxt.ist[IST_TXERR] | (|i_err_evt[N_ERR-1:N_RX_ERR]);
    s_nxt.ist[IST_SNAP] = s_nxt.ist[IST_SNAP] | s_r.snap;
    // Overflow keeps the line up until its secondary register is read
    s_nxt.irq = (|(s_nxt.ist & ~s_nxt.imask))
                | ((|s_nxt.ovf) && !s_nxt.imask[IST_OVF]);
    for (int w = 0; w < 3; w++) begin
      s_nxt.sta_out[47 - 16 * w -: 16] = {s_nxt.sta[w][7:0], s_nxt.sta[w][15:8]};
    end
    // Both watermarks compare against a long-word fill level
    s_nxt.ae = i_tx_fifo_words < s_r.wm_low;
    s_nxt.af = i_tx_fifo_words > s_r.wm_high;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.wm_low <= WM_LOW_RST;
      s_r.wm_high <= WM_HIGH_RST;
      s_r.imask <= IMASK_RST;
      s_r.ae <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign port.rdata = s_r.rdata;
  assign port.mgmt_port_ready = s_r.ready;
  assign port.irq = s_r.irq;
  assign o_station_addr = s_r.sta_out;
  assign o_tx_low_wm = s_r.wm_low;
  assign o_tx_high_wm = s_r.wm_high;
  assign o_tx_almost_empty = s_r.ae;
  assign o_tx_almost_full = s_r.af;
endmodule : mgmt_port_dev

// *** mgmt_port_host.sv ***
`timescale 1ns/1ps
module mgmt_port_host (
  input wire logic i_clk,
  input wire logic i_rst_n,
  mgmt_port_if.host port,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  import mgmt_pkg::*;

  typedef struct packed {
    host_state_t state;
    logic ack;
    logic [31:0] wb_dat;
    logic [31:0] ctrl;
    logic [9:0] base;
    logic [31:0] wdata;
    logic [31:0] last;
    logic [7:0] rcnt;
    logic [7:0] iss;
    logic sel_n;
    logic [9:0] addr;
    logic we;
  } host_t;
  host_t s_r, s_nxt;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    for (int b = 0; b < 4; b++) lane_merge[8 * b +: 8] = be[b] ? wd[8 * b +: 8] : old[8 * b +: 8];
  endfunction : lane_merge

  always_comb begin
    logic req;
    logic [7:0] len;
    logic [9:0] step;
    logic [31:0] mrg;
    s_nxt = s_r;
    mrg = lane_merge({22'h0, s_r.base}, i_wb_dat, i_wb_sel);
    req = i_wb_cyc && i_wb_stb && !s_r.ack;
    len = s_r.ctrl[CTRL_LEN_LSB +: 8] == 8'h0 ? 8'h1 : s_r.ctrl[CTRL_LEN_LSB +: 8];
    step = s_r.ctrl[CTRL_WIDE] ? 10'h4 : 10'h2;
    // ---------------------------------------------------------------
    // Wishbone slave, answer one cycle after the request
    // ---------------------------------------------------------------
    s_nxt.ack = req;
    s_nxt.ctrl[CTRL_START] = 1'b0;
    if (req && i_wb_we) begin
      case (i_wb_adr)
        HC_CTRL: begin
          s_nxt.ctrl = lane_merge(s_r.ctrl, i_wb_dat, i_wb_sel);
          s_nxt.ctrl[CTRL_START] = i_wb_sel[0] && i_wb_dat[CTRL_START] && s_r.state == H_IDLE;
          if (s_r.state != H_IDLE) s_nxt.ctrl = s_r.ctrl;
        end
        HC_ADDR: s_nxt.base = mrg[9:0];
        HC_WDATA: s_nxt.wdata = lane_merge(s_r.wdata, i_wb_dat, i_wb_sel);
        default: ;
      endcase
    end
    s_nxt.wb_dat = 32'h0;
    if (req && !i_wb_we) begin
      case (i_wb_adr)
        HC_CTRL: s_nxt.wb_dat = s_r.ctrl;
        HC_ADDR: s_nxt.wb_dat = {22'h0, s_r.base};
        HC_WDATA: s_nxt.wb_dat = s_r.wdata;
        HC_STATUS: s_nxt.wb_dat = {16'h0, s_r.rcnt, 6'h0, port.irq, s_r.state != H_IDLE};
        HC_RDATA: s_nxt.wb_dat = s_r.last;
        default: s_nxt.wb_dat = 32'h0;
      endcase
    end
    // ---------------------------------------------------------------
    // Port sequencer
    // ---------------------------------------------------------------
    case (s_r.state)
      H_IDLE: begin
        s_nxt.sel_n = 1'b1;
        if (s_r.ctrl[CTRL_START]) begin
          s_nxt.state = H_FIRST;
          s_nxt.sel_n = 1'b0;
          s_nxt.addr = s_r.base;
          s_nxt.we = s_r.ctrl[CTRL_WRITE];
          s_nxt.rcnt = 8'h0;
          s_nxt.iss = 8'h1;
        end
      end
      H_FIRST: begin
        // Address is held until the first ready
        if (port.mgmt_port_ready) begin
          s_nxt.rcnt = 8'h1;
          if (!s_r.we) s_nxt.last = port.rdata;
          if (s_r.we || len == 8'h1) begin
            s_nxt.state = H_GAP;
            s_nxt.sel_n = 1'b1;
          end else begin
            s_nxt.state = H_STREAM;
            s_nxt.addr = s_r.addr + step;
            s_nxt.iss = 8'h2;
          end
        end
      end
      H_STREAM: begin
        if (s_r.iss < len) begin
          s_nxt.addr = s_r.addr + step;
          s_nxt.iss = s_r.iss + 8'h1;
        end
        if (port.mgmt_port_ready) begin
          s_nxt.last = port.rdata;
          s_nxt.rcnt = s_r.rcnt + 8'h1;
          if (s_r.rcnt + 8'h1 == len) begin
            s_nxt.state = H_GAP;
            s_nxt.sel_n = 1'b1;
          end
        end
      end
      H_GAP: s_nxt.state = H_IDLE;
      default: s_nxt.state = H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.sel_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign port.mgmt_port_select_n = s_r.sel_n;
  assign port.addr = s_r.addr;
  assign port.we = s_r.we;
  assign port.wdata = s_r.wdata;
  assign port.wide = s_r.ctrl[CTRL_WIDE];
  assign o_wb_dat = s_r.wb_dat;
  assign o_wb_ack = s_r.ack;
endmodule : mgmt_port_host

// *** mgmt_port_props.sv ***
`timescale 1ns/1ps
module mgmt_port_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic mgmt_port_select_n,
  input wire logic [9:0] addr,
  input wire logic we,
  input wire logic wide,
  input wire logic [31:0] rdata,
  input wire logic mgmt_port_ready,
  input wire logic irq
);
  import mgmt_pkg::*;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------------------
  // Access history
  // ----------------------------
  logic sel_n_r, mask_wr_r, fresh, skew;
  logic [9:0] addr_r;
  assign fresh = !mgmt_port_select_n && (sel_n_r || addr != addr_r);
  assign skew = wide ? addr[1:0] != 2'h0 : addr[0];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_n_r <= 1'b1;
      addr_r <= 10'h0;
      mask_wr_r <= 1'b0;
    end else begin
      sel_n_r <= mgmt_port_select_n;
      addr_r <= addr;
      mask_wr_r <= mask_wr_r | (fresh & we & (addr == OFS_IMASK));
    end
  end
  sequence s_held;
    !mgmt_port_select_n ##1 !mgmt_port_select_n;
  endsequence
  property p_ready_third;
    fresh ##1 s_held |-> mgmt_port_ready;
  endproperty
  a_ready_third: assert property (p_ready_third) else $error("ready late");
  property p_ready_cause;
    mgmt_port_ready |-> $past(fresh, 2);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_ready_sel;
    mgmt_port_ready |-> !$past(mgmt_port_select_n) && !$past(mgmt_port_select_n, 2);
  endproperty
  a_ready_sel: assert property (p_ready_sel) else $error("ready after release");
  property p_idle;
    !mgmt_port_ready |-> rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("data outside ready");
  property p_narrow;
    mgmt_port_ready && !wide |-> rdata[31:16] == 16'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper half in narrow mode");
  property p_skew;
    fresh && skew ##1 s_held |-> rdata == 32'h0;
  endproperty
  a_skew: assert property (p_skew) else $error("misaligned access answered");
  property p_mask_rst;
    !mask_wr_r |-> !irq;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("irq before unmask");
  property p_hold;
    !mgmt_port_select_n && sel_n_r |=> mgmt_port_select_n || $stable(addr);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved early");
endmodule : mgmt_port_props

// *** mgmt_register_stats_port_bench.sv ***
`timescale 1ns/1ps
module mgmt_register_stats_port_bench;
  import mgmt_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, cyc = 1'b0, wwe = 1'b0, done = 1'b0, tg = 1'b0;
  logic rx_busy = 1'b0, tx_busy = 1'b0, good = 1'b1, ack, a_emp, a_full;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, odat, rdat;
  logic [15:0] len = 16'h0;
  logic [9:0] err = 10'h0;
  logic [10:0] fill = 11'h0, lo, hi, low_wm, high_wm;
  logic [47:0] src = 48'h0, sta, sa;
  int fail_count, checked, cnt[30], sn[30];
  int lens[12] = '{64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1520};
  mgmt_port_if i_mgmt_port_if ();
  mgmt_port_dev i_mgmt_port_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .port(i_mgmt_port_if), .i_rx_done(done),
    .i_rx_good(good), .i_rx_tagged(tg), .i_rx_len(len), .i_tx_done(done), .i_tx_good(good), .i_tx_tagged(tg),
    .i_tx_len(len), .i_err_evt(err), .i_rx_busy(rx_busy), .i_tx_busy(tx_busy), .i_tx_fifo_words(fill),
    .i_last_src(src), .o_station_addr(sta), .o_tx_low_wm(low_wm), .o_tx_high_wm(high_wm),
    .o_tx_almost_empty(a_emp), .o_tx_almost_full(a_full));
  mgmt_port_host i_mgmt_port_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .port(i_mgmt_port_if), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(wwe), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(odat),
    .o_wb_ack(ack));
  mgmt_port_props i_mgmt_port_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .mgmt_port_select_n(i_mgmt_port_if.mgmt_port_select_n), .addr(i_mgmt_port_if.addr),
    .we(i_mgmt_port_if.we), .wide(i_mgmt_port_if.wide), .rdata(i_mgmt_port_if.rdata),
    .mgmt_port_ready(i_mgmt_port_if.mgmt_port_ready), .irq(i_mgmt_port_if.irq));
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    checked++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic tmo;
    fail_count++;
    $display("BAD %0t no answer", $time);
    end_of_test();
  endtask : tmo
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    cyc <= 1'b1;
    wwe <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) tmo();
    rdat = odat;
    cyc <= 1'b0;
  endtask : wb
  task automatic dev(input logic w, wd, input logic [9:0] a, input logic [31:0] d, input logic [7:0] n8);
    int n;
    wb(1'b1, HC_ADDR, {22'h0, a});
    wb(1'b1, HC_WDATA, d);
    wb(1'b1, HC_CTRL, {16'h0, n8, 5'h0, wd, w, 1'b1});
    n = 0;
    do begin
      wb(1'b0, HC_STATUS, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 40);
    if (rdat[0] !== 1'b0) tmo();
    if (!w) chk(rdat[15:8], (n8 == 8'h0) ? 8'h1 : n8);
    wb(1'b0, HC_RDATA, 32'h0);
  endtask : dev
  task automatic rd(input logic wd, input logic [9:0] a, input logic [31:0] x);
    dev(1'b0, wd, a, 32'h0, 8'h0);
    chk(rdat, x);
  endtask : rd
  function automatic logic [31:0] aw(input logic [47:0] x, input int k);
    logic [47:0] t;
    t = x << (16 * k);
    return {16'h0, t[39:32], t[47:40]};
  endfunction : aw
  task automatic frame(input int l, input logic t);
    int b;
    int g;
    @(posedge i_clk);
    done <= 1'b1;
    len <= l[15:0];
    tg <= t;
    @(posedge i_clk);
    done <= 1'b0;
    b = l == 64 ? 0 : l < 128 ? 1 : l < 256 ? 2 : l < 512 ? 3 : l < 1024 ? 4 : 5;
    g = good;
    cnt[b] += g;
    cnt[b + 7] += g;
    cnt[6] += g;
    cnt[13] += g;
    cnt[26] += g * l;
    cnt[28] += g * l;
  endtask : frame
  initial begin
    void'($urandom(89471));
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(1'b1, OFS_TXWM, {5'h0, WM_HIGH_RST, 5'h0, WM_LOW_RST});
    rd(1'b1, OFS_IMASK, 32'hf);
    wb(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h0);
    $display("reset test done");
    lo = 11'($urandom_range(1, 999));
    hi = 11'($urandom_range(1000, 2000));
    dev(1'b1, 1'b1, OFS_TXWM, {5'h0, hi, 5'h0, lo}, 8'h0);
    fill <= lo - 11'h1;
    repeat (2) @(posedge i_clk);
    chk({a_emp, a_full, high_wm, low_wm}, {2'b10, hi, lo});
    fill <= hi + 11'h1;
    repeat (2) @(posedge i_clk);
    chk({a_emp, a_full}, 2'b01);
    lo = 11'($urandom_range(1, 999));
    hi = 11'($urandom_range(1000, 2000));
    dev(1'b1, 1'b0, OFS_TXWM, {21'h0, lo}, 8'h0);
    dev(1'b1, 1'b0, OFS_TXWM + 10'h2, {21'h0, hi}, 8'h0);
    chk({high_wm, low_wm}, {hi, lo});
    rd(1'b0, OFS_TXWM + 10'h2, {21'h0, hi});
    dev(1'b1, 1'b1, OFS_TXWM + 10'h2, 32'hffffffff, 8'h0);
    rd(1'b1, OFS_TXWM, {5'h0, hi, 5'h0, lo});
    rd(1'b1, OFS_TXWM + 10'h1, 32'h0);
    $display("watermark test done");
    sa = 48'({$urandom, $urandom});
    src <= ~sa;
    for (int i = 0; i < 3; i++) dev(1'b1, 1'b1, OFS_STA + 10'(4 * i), aw(sa, i), 8'h0);
    chk(sta, sa);
    for (int i = 0; i < 3; i++) rd(1'b1, OFS_LSA + 10'(4 * i), aw(~sa, i));
    $display("address test done");
    frame(64, 1'b0);
    rd(1'b1, 10'h118, 32'h0);
    dev(1'b1, 1'b1, OFS_STATCMD, 32'h1, 8'h0);
    foreach (lens[i]) frame(lens[i], i == 11);
    repeat (4) frame(int'($urandom_range(64, 1518)), 1'b0);
    good <= 1'b0;
    frame(300, 1'b0);
    good <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      rx_busy <= 1'b1;
      tx_busy <= i < 7;
      err <= 10'(1 << i);
      cnt[14 + i]++;
    end
    @(posedge i_clk);
    rx_busy <= 1'b0;
    tx_busy <= 1'b0;
    err <= 10'h0;
    cnt[24] += 10;
    cnt[25] += 7;
    for (int i = 0; i < 30; i++) rd(1'b1, 10'h100 + 10'(4 * i), cnt[i]);
    dev(1'b0, 1'b1, 10'h100, 32'h0, 8'h3);
    chk(rdat, cnt[2]);
    dev(1'b0, 1'b0, 10'h100, 32'h0, 8'h3);
    chk(rdat, cnt[1] & 32'hffff);
    $display("counter test done");
    sn = cnt;
    dev(1'b1, 1'b1, OFS_STATCMD, 32'h2, 8'h0);
    frame(100, 1'b0);
    rd(1'b1, 10'h104, sn[1]);
    rd(1'b1, 10'h118, sn[6]);
    chk(i_mgmt_port_if.irq, 1'b0);
    dev(1'b1, 1'b1, OFS_IMASK, 32'h7, 8'h0);
    chk(i_mgmt_port_if.irq, 1'b1);
    rd(1'b1, OFS_IST, 32'he);
    chk(i_mgmt_port_if.irq, 1'b0);
    rd(1'b1, OFS_IST, 32'h0);
    $display("snapshot test done");
    end_of_test();
  end
endmodule : mgmt_register_stats_port_bench
